// file: rtl/scp_pkg.sv
// Shared constants and types of the serial configuration port.
package scp_pkg;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int I2C_PERIOD_NS   = 2500;
  localparam int I2C_QUARTER_CYC = (I2C_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  localparam int INSTR_BITS      = 16;
  localparam int SPI_ADDR_BITS   = 13;
  localparam int BYTE_BITS       = 8;
  localparam int REG_ADDR_BITS   = 16;
  localparam int I2C_BYTE_CLKS   = 9;
  localparam int INSTR_RW_POS    = 15;
  localparam logic [4:0] I2C_ADDR_UPPER = 5'h15;
  localparam logic [1:0] STRAP_SPI      = 2'h0;

  typedef enum logic [2:0] {
    SCP_I_IDLE, SCP_I_DEV, SCP_I_AHI, SCP_I_ALO, SCP_I_WDAT, SCP_I_RDAT
  } scp_i2c_ph_t;

  typedef enum logic [1:0] {
    SCP_H_IDLE, SCP_H_START, SCP_H_STOP, SCP_H_BITS
  } scp_host_st_t;

  typedef enum logic [1:0] {
    SCP_CMD_START, SCP_CMD_STOP, SCP_CMD_WRITE, SCP_CMD_READ
  } scp_cmd_t;
endpackage : scp_pkg

// file: rtl/scp_if.sv
// Link between the host end and the device end: four-wire SPI and two-wire bus.
`timescale 1ns/1ns
interface scp_if;
  logic sclk;
  logic cs_n;
  logic sdi;
  logic sdo_o;
  logic sdo_oe;
  logic sdo;
  logic scl_o;
  logic scl_oe;
  logic scl;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda;

  // Open-drain lines with pull-ups; an idle SDO reads high.
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((sda_dev_oe & ~sda_dev_o) | (sda_host_oe & ~sda_host_o));
  assign sdo = sdo_oe ? sdo_o : 1'b1;

  modport dev (input sclk, cs_n, sdi, scl, sda, output sdo_o, sdo_oe, sda_dev_o, sda_dev_oe);
  modport host (input sdo, sda, output sclk, cs_n, sdi, scl_o, scl_oe, sda_host_o, sda_host_oe);
endinterface : scp_if

// file: rtl/scp_sync.sv
// Two-flop synchroniser for a group of asynchronous inputs.
`timescale 1ns/1ns
module scp_sync
  import scp_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_sys_rst,
  input  wire logic         i_clk_en,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  if (W < 1) $error("scp_sync needs at least one bit");

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } scp_sync_st_t;

  scp_sync_st_t r_r;
  scp_sync_st_t r_nxt;

  always_comb begin
    r_nxt    = r_r;
    r_nxt.s1 = i_async;
    r_nxt.s2 = r_r.s1;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      // Keeps sampling through reset, so settled straps stand at the output on release.
      r_r <= r_nxt;
    end else if (i_clk_en) begin
      r_r <= r_nxt;
    end
  end

  assign o_sync = r_r.s2;
endmodule : scp_sync

// file: rtl/scp_dev.sv
// Device end: SPI or two-wire slave giving register access to local logic.
`timescale 1ns/1ns
//
// Contract
// - Ascension bits clear: address steps down; two-wire mode steps up regardless.
// - Ascension bits set: address steps up.
// - Every address visited, none skipped.
// - Host fills reserved/unmapped locations sensibly.
// - Instruction is 16 bits, flag first.
// - Two top instruction address bits ignored.
// - Works at 100 kHz and 400 kHz.
// - Slave only; never drives the clock.
// - Two-wire registers use 16-bit addresses.
// - Answer only the matching slave address.
// - Address 10101 plus straps; 00 selects SPI.
// - Data changes only while clock low.
// - Start condition begins a transfer.
// - Stop condition ends a transfer.
// - Eight bits MSB first, then acknowledge.
// - Receiver acknowledges by holding data low.
// - Released data on ninth pulse is NACK.
// - After NACK go idle until start.
// - No glitch filtering on the bus.
// - Write: two address bytes, high first.
module scp_dev
  import scp_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_clk_en,
  scp_if.dev               link,
  input  wire logic        i_port_select_strap_low,
  input  wire logic        i_port_select_strap_high,
  input  wire logic        i_addr_ascend,
  input  wire logic [7:0]  i_reg_rdata,
  output logic      [15:0] o_reg_addr,
  output logic      [7:0]  o_reg_wdata,
  output logic             o_reg_we,
  output logic             o_reg_re,
  output logic             o_spi_mode
);
  typedef struct packed {
    logic                  captured;
    logic                  spi_mode;
    logic [1:0]            strap;
    logic                  p_sclk;
    logic                  p_scl;
    logic                  p_sda;
    logic [4:0]            icnt_spi;
    logic                  data_ph;
    logic                  rw;
    logic [2:0]            bitn;
    logic [15:0]           rx;
    logic [7:0]            tx;
    logic                  sdo;
    logic                  sdo_oe;
    scp_i2c_ph_t           iph;
    logic [3:0]            icnt;
    logic                  sda_oe;
    logic [15:0]           addr;
    logic [15:0]           reg_addr;
    logic [7:0]            wdata;
    logic                  we;
    logic                  re;
  } scp_dev_st_t;

  scp_dev_st_t r_r;
  scp_dev_st_t r_nxt;
  logic [6:0]  sync_q;
  logic        s_sclk;
  logic        s_cs_n;
  logic        s_sdi;
  logic        s_scl;
  logic        s_sda;
  logic        s_lo;
  logic        s_hi;

  // Pins cross into the reference clock; no spike filter follows.
  scp_sync #(
    .W (7)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_clk_en  (i_clk_en),
    .i_async   ({link.sclk, link.cs_n, link.sdi, link.scl, link.sda,
                 i_port_select_strap_low, i_port_select_strap_high}),
    .o_sync    (sync_q)
  );

  assign {s_sclk, s_cs_n, s_sdi, s_scl, s_sda, s_lo, s_hi} = sync_q;

  function automatic logic [15:0] spi_step(input logic [15:0] a, input logic up);
    logic [12:0] n;
    n = up ? a[12:0] + 13'h1 : a[12:0] - 13'h1;
    return {3'h0, n};
  endfunction

  always_comb begin
    logic sclk_rise;
    logic sclk_fall;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic [15:0] nxt_a;
    logic [6:0]  own_a;
    sclk_rise = s_sclk & ~r_r.p_sclk;
    sclk_fall = ~s_sclk & r_r.p_sclk;
    scl_rise  = s_scl & ~r_r.p_scl;
    scl_fall  = ~s_scl & r_r.p_scl;
    start_c   = r_r.p_scl & s_scl & r_r.p_sda & ~s_sda;
    stop_c    = r_r.p_scl & s_scl & ~r_r.p_sda & s_sda;
    nxt_a     = spi_step(r_r.addr, i_addr_ascend);
    // Strap pair 01 answers at the lower address, 11 at the one just above it.
    own_a     = {I2C_ADDR_UPPER, r_r.strap[1] & ~r_r.strap[0], r_r.strap[1] & r_r.strap[0]};
    r_nxt        = r_r;
    r_nxt.we     = 1'b0;
    r_nxt.re     = 1'b0;
    r_nxt.p_sclk = s_sclk;
    r_nxt.p_scl  = s_scl;
    r_nxt.p_sda  = s_sda;
    if (!r_r.captured) begin
      // Straps are taken once after reset release and then held.
      r_nxt.captured = 1'b1;
      r_nxt.strap    = {s_hi, s_lo};
      r_nxt.spi_mode = ({s_hi, s_lo} == STRAP_SPI);
    end else if (r_r.spi_mode) begin
      if (s_cs_n) begin
        r_nxt.icnt_spi = '0;
        r_nxt.data_ph  = 1'b0;
        r_nxt.bitn     = '0;
        r_nxt.sdo_oe   = 1'b0;
      end else begin
        r_nxt.sdo_oe = r_r.data_ph & r_r.rw;
        if (sclk_rise) begin
          if (!r_r.data_ph) begin
            r_nxt.rx       = {r_r.rx[14:0], s_sdi};
            r_nxt.icnt_spi = r_r.icnt_spi + 5'h1;
            if (r_r.icnt_spi == 5'(INSTR_BITS - 1)) begin
              r_nxt.data_ph  = 1'b1;
              r_nxt.rw       = r_r.rx[INSTR_RW_POS - 1];
              // Top two address bits are dropped.
              r_nxt.addr     = {3'h0, r_r.rx[SPI_ADDR_BITS-2:0], s_sdi};
              r_nxt.reg_addr = {3'h0, r_r.rx[SPI_ADDR_BITS-2:0], s_sdi};
              r_nxt.re       = r_r.rx[INSTR_RW_POS - 1];
            end
          end else begin
            r_nxt.rx[7:0] = {r_r.rx[6:0], s_sdi};
            r_nxt.bitn    = r_r.bitn + 3'h1;
            if (r_r.bitn == 3'(BYTE_BITS - 1)) begin
              // Step one address per byte, reserved ones included.
              r_nxt.addr = nxt_a;
              if (r_r.rw) begin
                r_nxt.reg_addr = nxt_a;
                r_nxt.re       = 1'b1;
              end else begin
                r_nxt.reg_addr = r_r.addr;
                r_nxt.wdata    = {r_r.rx[6:0], s_sdi};
                r_nxt.we       = 1'b1;
              end
            end
          end
        end
        if (sclk_fall && r_r.data_ph && r_r.rw) begin
          if (r_r.bitn == 3'h0) begin
            r_nxt.sdo = i_reg_rdata[7];
            r_nxt.tx  = {i_reg_rdata[6:0], 1'b0};
          end else begin
            r_nxt.sdo = r_r.tx[7];
            r_nxt.tx  = {r_r.tx[6:0], 1'b0};
          end
        end
      end
    end else begin
      if (start_c) begin
        r_nxt.iph    = SCP_I_DEV;
        r_nxt.icnt   = '0;
        r_nxt.sda_oe = 1'b0;
      end else if (stop_c) begin
        r_nxt.iph    = SCP_I_IDLE;
        r_nxt.sda_oe = 1'b0;
      end else if (r_r.iph != SCP_I_IDLE) begin
        if (scl_rise) begin
          if (r_r.icnt < 4'(BYTE_BITS)) begin
            r_nxt.rx[7:0] = {r_r.rx[6:0], s_sda};
            r_nxt.icnt    = r_r.icnt + 4'h1;
          end else begin
            r_nxt.icnt = '0;
            // After the address byte the ninth bit is our own acknowledge, not the master's.
            if (r_r.iph == SCP_I_RDAT && !r_r.sda_oe) begin
              if (s_sda) begin
                r_nxt.iph = SCP_I_IDLE;
              end else begin
                r_nxt.addr     = r_r.addr + 16'h1;
                r_nxt.reg_addr = r_r.addr + 16'h1;
                r_nxt.re       = 1'b1;
              end
            end
          end
        end
        // The data line only moves on a falling clock.
        if (scl_fall) begin
          if (r_r.icnt == 4'(I2C_BYTE_CLKS - 1)) begin
            case (r_r.iph)
              SCP_I_DEV: begin
                if (r_r.rx[7:1] == own_a) begin
                  r_nxt.sda_oe = 1'b1;
                  r_nxt.iph    = r_r.rx[0] ? SCP_I_RDAT : SCP_I_AHI;
                  // A read without address bytes resumes here.
                  r_nxt.reg_addr = r_r.addr;
                  r_nxt.re       = r_r.rx[0];
                end else begin
                  r_nxt.iph = SCP_I_IDLE;
                end
              end
              SCP_I_AHI: begin
                r_nxt.addr[15:8] = r_r.rx[7:0];
                r_nxt.sda_oe     = 1'b1;
                r_nxt.iph        = SCP_I_ALO;
              end
              SCP_I_ALO: begin
                r_nxt.addr[7:0] = r_r.rx[7:0];
                r_nxt.sda_oe    = 1'b1;
                r_nxt.iph       = SCP_I_WDAT;
              end
              SCP_I_WDAT: begin
                r_nxt.reg_addr = r_r.addr;
                r_nxt.wdata    = r_r.rx[7:0];
                r_nxt.we       = 1'b1;
                r_nxt.addr     = r_r.addr + 16'h1;
                r_nxt.sda_oe   = 1'b1;
              end
              default: begin
                r_nxt.sda_oe = 1'b0;
              end
            endcase
          end else if (r_r.iph == SCP_I_RDAT) begin
            if (r_r.icnt == 4'h0) begin
              r_nxt.sda_oe = ~i_reg_rdata[7];
              r_nxt.tx     = {i_reg_rdata[6:0], 1'b0};
            end else begin
              r_nxt.sda_oe = ~r_r.tx[7];
              r_nxt.tx     = {r_r.tx[6:0], 1'b0};
            end
          end else begin
            r_nxt.sda_oe = 1'b0;
          end
        end
      end else begin
        r_nxt.sda_oe = 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      r_r     <= '0;
      r_r.iph <= SCP_I_IDLE;
    end else if (i_clk_en) begin
      r_r <= r_nxt;
    end
  end

  // The device has no clock output at all on the two-wire bus.
  assign link.sda_dev_o  = 1'b0;
  assign link.sda_dev_oe = r_r.sda_oe;
  assign link.sdo_o      = r_r.sdo;
  assign link.sdo_oe     = r_r.sdo_oe;
  assign o_reg_addr      = r_r.reg_addr;
  assign o_reg_wdata     = r_r.wdata;
  assign o_reg_we        = r_r.we;
  assign o_reg_re        = r_r.re;
  assign o_spi_mode      = r_r.spi_mode;
endmodule : scp_dev

// file: rtl/scp_host.sv
// Host end: byte-level SPI or two-wire master driven by a command port.
`timescale 1ns/1ns
module scp_host
  import scp_pkg::*;
#(
  parameter int QUARTER_CYC = I2C_QUARTER_CYC
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_clk_en,
  scp_if.host             link,
  input  wire logic       i_use_spi,
  input  wire logic       i_cmd_valid,
  input  wire scp_cmd_t   i_cmd,
  input  wire logic [7:0] i_cmd_data,
  input  wire logic       i_cmd_nack,
  output logic            o_cmd_ready,
  output logic            o_rsp_valid,
  output logic [7:0]      o_rsp_data,
  output logic            o_rsp_ack
);
  if (QUARTER_CYC < 2 || QUARTER_CYC > 255) $error("scp_host quarter period out of range");

  typedef struct packed {
    scp_host_st_t st;
    logic [1:0]   q;
    logic [7:0]   qcnt;
    logic [3:0]   bitn;
    logic [8:0]   tx;
    logic [8:0]   rx;
    logic         scl_low;
    logic         sda_low;
    logic         cs_n;
    logic         sclk;
    logic         rsp_valid;
    logic [7:0]   rsp_data;
    logic         rsp_ack;
  } scp_host_r_t;

  scp_host_r_t r_r;
  scp_host_r_t r_nxt;
  logic [1:0]  s_in;

  scp_sync #(
    .W (2)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_clk_en  (i_clk_en),
    .i_async   ({link.sdo, link.sda}),
    .o_sync    (s_in)
  );

  always_comb begin
    logic tick;
    logic last;
    tick            = (r_r.qcnt == 8'(QUARTER_CYC - 1));
    last            = (r_r.bitn == (i_use_spi ? 4'(BYTE_BITS - 1) : 4'(I2C_BYTE_CLKS - 1)));
    r_nxt           = r_r;
    r_nxt.rsp_valid = 1'b0;
    r_nxt.qcnt      = tick ? 8'h0 : r_r.qcnt + 8'h1;
    case (r_r.st)
      SCP_H_IDLE: begin
        r_nxt.qcnt = '0;
        r_nxt.q    = '0;
        r_nxt.bitn = '0;
        if (i_cmd_valid) begin
          case (i_cmd)
            SCP_CMD_START: r_nxt.st = SCP_H_START;
            SCP_CMD_STOP:  r_nxt.st = SCP_H_STOP;
            default:       r_nxt.st = SCP_H_BITS;
          endcase
          // Ninth bit: released to read the ack, or our own ack on a read.
          if (i_use_spi) begin
            r_nxt.tx = {i_cmd_data, 1'b0};
          end else if (i_cmd == SCP_CMD_READ) begin
            r_nxt.tx = {8'hff, i_cmd_nack};
          end else begin
            r_nxt.tx = {i_cmd_data, 1'b1};
          end
        end
      end
      SCP_H_START: begin
        if (tick) begin
          r_nxt.q = r_r.q + 2'h1;
          case (r_r.q)
            2'h0: r_nxt.sda_low = 1'b0;
            2'h1: r_nxt.scl_low = 1'b0;
            2'h2: begin
              r_nxt.sda_low = ~i_use_spi;
              r_nxt.cs_n    = ~i_use_spi;
            end
            default: begin
              r_nxt.scl_low   = ~i_use_spi;
              r_nxt.st        = SCP_H_IDLE;
              r_nxt.rsp_valid = 1'b1;
            end
          endcase
        end
      end
      SCP_H_STOP: begin
        if (tick) begin
          r_nxt.q = r_r.q + 2'h1;
          case (r_r.q)
            2'h0: r_nxt.sda_low = ~i_use_spi;
            2'h1: r_nxt.scl_low = 1'b0;
            2'h2: r_nxt.sda_low = 1'b0;
            default: begin
              r_nxt.cs_n      = 1'b1;
              r_nxt.sclk      = 1'b0;
              r_nxt.st        = SCP_H_IDLE;
              r_nxt.rsp_valid = 1'b1;
            end
          endcase
        end
      end
      default: begin
        if (tick) begin
          r_nxt.q = r_r.q + 2'h1;
          case (r_r.q)
            2'h0: r_nxt.sda_low = ~i_use_spi & ~r_r.tx[8];
            2'h1: begin
              r_nxt.scl_low = 1'b0;
              r_nxt.sclk    = i_use_spi;
            end
            2'h2: r_nxt.rx = {r_r.rx[7:0], i_use_spi ? s_in[1] : s_in[0]};
            default: begin
              r_nxt.scl_low = ~i_use_spi;
              r_nxt.sclk    = 1'b0;
              r_nxt.tx      = {r_r.tx[7:0], 1'b1};
              r_nxt.bitn    = r_r.bitn + 4'h1;
              if (last) begin
                r_nxt.st        = SCP_H_IDLE;
                r_nxt.rsp_valid = 1'b1;
                r_nxt.rsp_data  = i_use_spi ? r_r.rx[7:0] : r_r.rx[8:1];
                r_nxt.rsp_ack   = ~i_use_spi & ~r_r.rx[0];
              end
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      r_r      <= '0;
      r_r.st   <= SCP_H_IDLE;
      r_r.cs_n <= 1'b1;
    end else if (i_clk_en) begin
      r_r <= r_nxt;
    end
  end

  assign link.sclk        = r_r.sclk;
  assign link.cs_n        = r_r.cs_n;
  assign link.sdi         = r_r.tx[8];
  assign link.scl_o       = 1'b0;
  assign link.scl_oe      = r_r.scl_low;
  assign link.sda_host_o  = 1'b0;
  assign link.sda_host_oe = r_r.sda_low;
  assign o_cmd_ready      = (r_r.st == SCP_H_IDLE);
  assign o_rsp_valid      = r_r.rsp_valid;
  assign o_rsp_data       = r_r.rsp_data;
  assign o_rsp_ack        = r_r.rsp_ack;
endmodule : scp_host

// file: test/scp_chk.sv
// Wire-level checks on the link between the host end and the device end.
`timescale 1ns/1ns
module scp_chk (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire logic scl_oe,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_oe
);
  logic       scl_q, sda_q, sclk_q, rw_q, idle_q;
  logic [3:0] bit_q;
  logic [4:0] spi_q;
  logic       rise;
  assign rise = scl & ~scl_q;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // Pulse count restarts at start and stop; idle follows a stop or a released ninth bit.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      sclk_q <= 1'b0;
      rw_q   <= 1'b0;
      idle_q <= 1'b1;
      bit_q  <= 4'h0;
      spi_q  <= 5'h00;
    end else begin
      scl_q  <= scl;
      sda_q  <= sda;
      sclk_q <= sclk;
      if (scl && scl_q && sda_q != sda) begin
        bit_q  <= 4'h0;
        idle_q <= sda;
      end else if (rise) begin
        bit_q <= (bit_q == 4'h9) ? 4'h1 : bit_q + 4'h1;
        if (bit_q == 4'h8 && sda) idle_q <= 1'b1;
      end
      if (cs_n) spi_q <= 5'h00;
      else if (sclk && !sclk_q && spi_q != 5'h1f) spi_q <= spi_q + 5'h01;
      if (!cs_n && sclk && !sclk_q && spi_q == 5'h00) rw_q <= sdi;
    end
  end
  clk_not_driven_a: assert property (!scl |-> scl_oe)
    else $error("scl low without host pull");
  sda_steady_a: assert property ($changed(sda_dev_oe) |-> !scl && !$past(scl))
    else $error("device sda moved while scl high");
  ack_low_a: assert property (rise && bit_q == 4'h8 && sda_dev_oe |-> (!sda && sda_dev_oe) [*4])
    else $error("device ack not held low");
  idle_quiet_a: assert property (idle_q |-> !sda_dev_oe)
    else $error("device drives sda while idle");
  instr_quiet_a: assert property (!cs_n && spi_q < 5'h10 |-> !sdo_oe)
    else $error("sdo driven inside instruction");
  write_quiet_a: assert property (!cs_n && !rw_q && spi_q != 5'h00 |-> !sdo_oe)
    else $error("sdo driven during write");
  read_drive_a: assert property (!cs_n && rw_q && sclk && spi_q > 5'h10 |-> sdo_oe)
    else $error("sdo not driven during read");
  sdo_steady_a: assert property (sclk && sclk_q && sdo_oe && $past(sdo_oe) |-> $stable(sdo_o))
    else $error("sdo moved while sclk high");
  cs_release_a: assert property (cs_n [*5] |-> !sdo_oe)
    else $error("sdo driven while deselected");
  cover property (rise && bit_q == 4'h8 && sda_dev_oe);
  cover property (rise && bit_q == 4'h8 && sda);
  cover property (!cs_n && rw_q && sdo_oe);
  cover property (!cs_n && !rw_q && spi_q == 5'h1f);
endmodule : scp_chk

// file: test/tb.sv
// Self-checking bench joining the host end and the device end over one link.
`timescale 1ns/1ns
module tb;
  import scp_pkg::*;
  localparam logic [17:0] NC = 18'h00000, ACK = 18'h20100, NAK = 18'h20000;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        use_spi = 1'b1;
  logic        cmd_valid = 1'b0;
  scp_cmd_t    cmd_kind = SCP_CMD_START;
  logic [7:0]  cmd_data = 8'h00;
  logic        cmd_nack = 1'b0;
  logic        strap_lo = 1'b0;
  logic        strap_hi = 1'b0;
  logic        ascend = 1'b0;
  logic        cmd_ready, rsp_valid, rsp_ack, reg_we, reg_re, spi_mode;
  logic [7:0]  rsp_data, reg_wdata, rdata;
  logic [15:0] reg_addr, ptr;
  logic [17:0] rexp;
  logic [6:0]  dev;
  logic [23:0] wq[$];
  logic [17:0] rq[$];
  int          n_fail = 0;
  int          compares = 0;
  int          seed, s;

  function automatic logic [7:0] rdv(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction : rdv

  always #5 ref_clk = ~ref_clk;
  assign rdata = rdv(reg_addr);
  scp_if scp_if_inst ();
  scp_host #(.QUARTER_CYC(5)) scp_host_inst (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_clk_en(1'b1),
    .link(scp_if_inst), .i_use_spi(use_spi), .i_cmd_valid(cmd_valid), .i_cmd(cmd_kind), .i_cmd_data(cmd_data),
    .i_cmd_nack(cmd_nack), .o_cmd_ready(cmd_ready), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
    .o_rsp_ack(rsp_ack));
  scp_dev scp_dev_inst (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_clk_en(1'b1), .link(scp_if_inst),
    .i_port_select_strap_low(strap_lo), .i_port_select_strap_high(strap_hi), .i_addr_ascend(ascend),
    .i_reg_rdata(rdata), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata), .o_reg_we(reg_we), .o_reg_re(reg_re),
    .o_spi_mode(spi_mode));
  scp_chk scp_chk_inst (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .sclk(scp_if_inst.sclk),
    .cs_n(scp_if_inst.cs_n), .sdi(scp_if_inst.sdi), .sdo_o(scp_if_inst.sdo_o), .sdo_oe(scp_if_inst.sdo_oe),
    .scl_oe(scp_if_inst.scl_oe), .scl(scp_if_inst.scl), .sda(scp_if_inst.sda),
    .sda_dev_oe(scp_if_inst.sda_dev_oe));

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  // Results are compared against the oldest note when they appear.
  always @(posedge ref_clk) begin
    if (reg_we === 1'b1) begin
      if (wq.size() == 0) check(24'h1, 24'h0);
      else check({reg_addr, reg_wdata}, wq.pop_front());
    end
    if (reg_re === 1'b1) check({23'h0, reg_we}, 24'h0);
    if (rsp_valid === 1'b1) begin
      if (rq.size() == 0) check(24'h1, 24'h0);
      else begin
        rexp = rq.pop_front();
        check({15'h0, {rsp_ack, rsp_data} & rexp[17:9]}, {15'h0, rexp[8:0]});
      end
    end
  end

  task automatic wait_idle(input logic all);
    int k;
    k = 0;
    while (!(cmd_ready === 1'b1 && (!all || rq.size() + wq.size() == 0)) && k < 5000) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    if (k == 5000) begin
      n_fail++;
      final_report();
    end
  endtask : wait_idle

  task automatic cmd(input scp_cmd_t c, input logic [7:0] d, input logic nk, input logic [17:0] e);
    wait_idle(1'b0);
    rq.push_back(e);
    cmd_valid = 1'b1;
    cmd_kind = c;
    cmd_data = d;
    cmd_nack = nk;
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b0;
  endtask : cmd

  task automatic do_reset(input logic [1:0] st);
    sys_rst = 1'b1;
    strap_hi = st[1];
    strap_lo = st[0];
    repeat (20) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask : do_reset

  task automatic spi_xfer(input logic rd, input logic [15:0] a, input int n, input logic up);
    logic [12:0] p;
    logic [7:0]  d;
    p = a[12:0];
    ascend = up;
    cmd(SCP_CMD_START, 8'h00, 1'b0, NC);
    cmd(SCP_CMD_WRITE, {rd, a[14:8]}, 1'b0, NC);
    cmd(SCP_CMD_WRITE, a[7:0], 1'b0, NC);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      if (rd) cmd(SCP_CMD_READ, 8'hff, 1'b0, {9'h0ff, 1'b0, rdv({3'h0, p})});
      else begin
        wq.push_back({3'h0, p, d});
        cmd(SCP_CMD_WRITE, d, 1'b0, NC);
      end
      p = up ? p + 13'h1 : p - 13'h1;
    end
    cmd(SCP_CMD_STOP, 8'h00, 1'b0, NC);
  endtask : spi_xfer

  task automatic i2c_wr(input logic [15:0] a, input int n);
    logic [7:0] d;
    cmd(SCP_CMD_START, 8'h00, 1'b0, NC);
    cmd(SCP_CMD_WRITE, {dev, 1'b0}, 1'b0, ACK);
    cmd(SCP_CMD_WRITE, a[15:8], 1'b0, ACK);
    cmd(SCP_CMD_WRITE, a[7:0], 1'b0, ACK);
    ptr = a;
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      wq.push_back({ptr, d});
      cmd(SCP_CMD_WRITE, d, 1'b0, ACK);
      ptr = ptr + 16'h1;
    end
    cmd(SCP_CMD_STOP, 8'h00, 1'b0, NC);
  endtask : i2c_wr

  task automatic i2c_rd(input logic seta, input logic [15:0] a, input int n);
    cmd(SCP_CMD_START, 8'h00, 1'b0, NC);
    if (seta) begin
      cmd(SCP_CMD_WRITE, {dev, 1'b0}, 1'b0, ACK);
      cmd(SCP_CMD_WRITE, a[15:8], 1'b0, ACK);
      cmd(SCP_CMD_WRITE, a[7:0], 1'b0, ACK);
      ptr = a;
      cmd(SCP_CMD_START, 8'h00, 1'b0, NC);
    end
    cmd(SCP_CMD_WRITE, {dev, 1'b1}, 1'b0, ACK);
    for (int i = 0; i < n; i++) begin
      cmd(SCP_CMD_READ, 8'hff, i == n - 1, {9'h0ff, 1'b0, rdv(ptr)});
      if (i < n - 1) ptr = ptr + 16'h1;
    end
    cmd(SCP_CMD_WRITE, 8'h00, 1'b0, NAK);
    cmd(SCP_CMD_STOP, 8'h00, 1'b0, NC);
  endtask : i2c_rd

  initial begin
    seed = $urandom(58308);
    do_reset(STRAP_SPI);
    check({23'h0, spi_mode}, 24'h1);
    spi_xfer(1'b0, 16'h6005, 2, 1'b0);
    spi_xfer(1'b0, 16'h1ffe, 3, 1'b1);
    spi_xfer(1'b0, 16'h2001, 3, 1'b0);
    spi_xfer(1'b1, 16'($urandom), 3, 1'b1);
    spi_xfer(1'b1, 16'($urandom), 2, 1'b0);
    wait_idle(1'b1);
    for (s = 1; s < 4; s += 2) begin
      dev = {I2C_ADDR_UPPER, 1'b0, s[1]};
      use_spi = 1'b0;
      do_reset(s[1:0]);
      check({23'h0, spi_mode}, 24'h0);
      cmd(SCP_CMD_START, 8'h00, 1'b0, NC);
      cmd(SCP_CMD_WRITE, {dev ^ 7'h01, 1'b0}, 1'b0, NAK);
      cmd(SCP_CMD_STOP, 8'h00, 1'b0, NC);
      i2c_wr(16'($urandom), 2);
      i2c_rd(1'b0, 16'h0000, 3);
      i2c_rd(1'b1, 16'($urandom), 2);
      wait_idle(1'b1);
    end
    final_report();
  end
endmodule : tb
